// [pcs_top.sv]
// program counter with page latch and return stack
`timescale 1ns/10ps
module pcs_top (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        fetch_adv,
  input  wire logic        goto_req,
  input  wire logic        call_req,
  input  wire logic        ret_req,
  input  wire logic        int_vec_req,
  input  wire logic [10:0] branch_target,
  input  wire logic        low_wr,
  input  wire logic [7:0]  low_wr_data,
  input  wire logic        low_add,
  input  wire logic [7:0]  low_add_offset,
  input  wire logic        latch_wr,
  input  wire logic [7:0]  latch_wr_data,
  output logic      [12:0] pc_q,
  output logic      [7:0]  pc_low_byte_q,
  output logic      [7:0]  pc_high_latch_q
);

  pcs_pkg::pcs_op_e op;
  logic [12:0]      pc_d;
  logic [4:0]       latch_q;
  logic [1:0]       page_bits;
  logic [8:0]       add_full;
  logic [7:0]       add_sum;
  logic             push;
  logic             pop;
  logic [12:0]      stk_top;
  logic [2:0]       stk_ptr;

  // one request per cycle is expected; if several arrive, the
  // decoder order below decides and the rest are dropped
  always_comb begin
    if (int_vec_req) begin
      op = pcs_pkg::OP_INT;
    end else if (ret_req) begin
      op = pcs_pkg::OP_RET;
    end else if (call_req) begin
      op = pcs_pkg::OP_CALL;
    end else if (goto_req) begin
      op = pcs_pkg::OP_GOTO;
    end else if (low_wr) begin
      op = pcs_pkg::OP_WLOW;
    end else if (low_add) begin
      op = pcs_pkg::OP_ADD;
    end else if (fetch_adv) begin
      op = pcs_pkg::OP_SEQ;
    end else begin
      op = pcs_pkg::OP_HOLD;
    end
  end

  // page select for branches; nonzero values reach unpopulated pages
  assign page_bits = latch_q[pcs_pkg::PAGE_MSB:pcs_pkg::PAGE_LSB];

  // carry out of the low byte is dropped, so tables must not
  // straddle a 256-word block
  assign add_full = {1'b0, pc_q[7:0]} + {1'b0, low_add_offset};
  assign add_sum  = add_full[7:0];

  always_comb begin
    pc_d = pc_q;
    push = 1'b0;
    pop  = 1'b0;
    unique case (op)
      pcs_pkg::OP_INT: begin
        pc_d = pcs_pkg::INT_VECTOR;
        push = 1'b1;
      end
      pcs_pkg::OP_RET: begin
        pc_d = stk_top;
        pop  = 1'b1;
      end
      pcs_pkg::OP_CALL: begin
        pc_d = {page_bits, branch_target};
        push = 1'b1;
      end
      pcs_pkg::OP_GOTO: begin
        pc_d = {page_bits, branch_target};
      end
      pcs_pkg::OP_WLOW: begin
        pc_d = {latch_q, low_wr_data};
      end
      pcs_pkg::OP_ADD: begin
        pc_d = {latch_q, add_sum};
      end
      pcs_pkg::OP_SEQ: begin
        pc_d = pc_q + pcs_pkg::PC_STEP;
      end
      pcs_pkg::OP_HOLD: begin
        pc_d = pc_q;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pc_q <= pcs_pkg::PC_RST;
    end else begin
      pc_q <= pc_d;
    end
  end

  // software sees the low byte only; the upper bits have no read path
  // outputs leave straight from flops; the low byte copy follows pc_d
  // so it never lags the counter, the latch copy repeats the latch write
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_low_byte_q <= pcs_pkg::PC_RST[7:0];
    end else begin
      pc_low_byte_q <= pc_d[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pc_high_latch_q <= {3'h0, pcs_pkg::LATCH_RST};
    end else if (latch_wr) begin
      pc_high_latch_q <= {3'h0, latch_wr_data[4:0]};
    end
  end

  // latch has no stack connection at all, so push and pop cannot touch it
  pcs_latch u_latch (
    .clk     (clk),
    .srst    (srst),
    .wr      (latch_wr),
    .wr_data (latch_wr_data),
    .latch_q (latch_q)
  );

  // pointer stays internal and there is no over/underflow flag
  pcs_stack u_stack (
    .clk       (clk),
    .srst      (srst),
    .push      (push),
    .pop       (pop),
    .push_data (pc_q),
    .top       (stk_top),
    .ptr_q     (stk_ptr)
  );

  // checks

  reset_clear_a:
    assert property (@(posedge clk)
      $fell(srst) |-> (pc_q == pcs_pkg::PC_RST) && (pc_high_latch_q == 8'h00) && (stk_ptr == 3'h0))
    else $error("counter, latch or pointer not cleared by reset");

  low_write_load_a:
    assert property (@(posedge clk) disable iff (srst)
      (op == pcs_pkg::OP_WLOW) |=>
        (pc_q == {$past(latch_q), $past(low_wr_data)}))
    else $error("low byte write did not load upper bits from latch");

  goto_page_a:
    assert property (@(posedge clk) disable iff (srst)
      (op == pcs_pkg::OP_GOTO) |=>
        (pc_q[12:11] == $past(latch_q[4:3])) && (pc_q[10:0] == $past(branch_target)))
    else $error("jump target or page bits wrong");

  call_target_a:
    assert property (@(posedge clk) disable iff (srst)
      (op == pcs_pkg::OP_CALL) |=>
        (pc_q == {$past(latch_q[4:3]), $past(branch_target)}) &&
        (stk_ptr == $past(stk_ptr) + 3'h1))
    else $error("call did not branch and push");

  call_return_a:
    assert property (@(posedge clk) disable iff (srst)
      (op == pcs_pkg::OP_CALL) ##1 (op == pcs_pkg::OP_RET) |=>
        (pc_q == $past(pc_q, 2)))
    else $error("return did not restore the full counter");

  int_vector_a:
    assert property (@(posedge clk) disable iff (srst)
      (op == pcs_pkg::OP_INT) |=>
        (pc_q == pcs_pkg::INT_VECTOR) && (stk_ptr == $past(stk_ptr) + 3'h1))
    else $error("interrupt did not vector and push");

  int_return_a:
    assert property (@(posedge clk) disable iff (srst)
      (op == pcs_pkg::OP_INT) ##1 (op == pcs_pkg::OP_SEQ) [*2] ##1 (op == pcs_pkg::OP_RET) |=>
        (pc_q == $past(pc_q, 4)) && (stk_ptr == $past(stk_ptr, 4)))
    else $error("interrupt return lost the saved counter");

  latch_stable_a:
    assert property (@(posedge clk) disable iff (srst)
      (push || pop) && !latch_wr |=> $stable(pc_high_latch_q))
    else $error("stack operation changed the high latch");

  latch_write_a:
    assert property (@(posedge clk) disable iff (srst)
      latch_wr |=> (pc_high_latch_q == {3'h0, $past(latch_wr_data[4:0])}))
    else $error("high latch write not stored");

  pop_ptr_a:
    assert property (@(posedge clk) disable iff (srst)
      (op == pcs_pkg::OP_RET) |=>
        (stk_ptr == $past(stk_ptr) - 3'h1) && (pc_q == $past(stk_top)))
    else $error("return did not pop the stack");

  wrap_push_a:
    assert property (@(posedge clk) disable iff (srst)
      push && (stk_ptr == 3'h7) |=> (stk_ptr == 3'h0))
    else $error("stack pointer did not wrap");

  wrap_pop_a:
    assert property (@(posedge clk) disable iff (srst)
      pop && (stk_ptr == 3'h0) |=> (stk_ptr == 3'h7))
    else $error("stack pointer did not wrap on underflow");

  seq_advance_a:
    assert property (@(posedge clk) disable iff (srst)
      (op == pcs_pkg::OP_SEQ) |=> (pc_q == $past(pc_q) + 13'h0001))
    else $error("counter did not advance by one");

  add_jump_a:
    assert property (@(posedge clk) disable iff (srst)
      (op == pcs_pkg::OP_ADD) |=>
        (pc_q[7:0] == $past(pc_q[7:0]) + $past(low_add_offset)) &&
        (pc_q[12:8] == $past(latch_q)))
    else $error("computed jump result wrong");

  hold_a:
    assert property (@(posedge clk) disable iff (srst)
      (op == pcs_pkg::OP_HOLD) |=> $stable(pc_q) && $stable(stk_ptr))
    else $error("counter moved with no request");

  reset_hold_a:
    assert property (@(posedge clk)
      srst |=>
        (pc_q == pcs_pkg::PC_RST) && (stk_ptr == pcs_pkg::PTR_RST) && (pc_low_byte_q == 8'h00))
    else $error("reset did not hold the counter at zero");

  low_mirror_a:
    assert property (@(posedge clk) disable iff (srst)
      pc_low_byte_q == pc_q[7:0])
    else $error("low byte output differs from the counter");

  latch_mirror_a:
    assert property (@(posedge clk) disable iff (srst)
      pc_high_latch_q == {3'h0, latch_q})
    else $error("latch output differs from the stored latch");

  latch_idle_a:
    assert property (@(posedge clk) disable iff (srst)
      !latch_wr |=> $stable(latch_q))
    else $error("latch changed without a latch write");

  stk_idle_a:
    assert property (@(posedge clk) disable iff (srst)
      !push && !pop |=> $stable(stk_ptr))
    else $error("stack pointer moved without push or pop");

  int_first_a:
    assert property (@(posedge clk) disable iff (srst)
      int_vec_req |->
        (op == pcs_pkg::OP_INT) && push && !pop)
    else $error("interrupt request did not push");

  ret_pop_a:
    assert property (@(posedge clk) disable iff (srst)
      ret_req && !int_vec_req |->
        pop && !push)
    else $error("return request did not pop");

  pop_top_a:
    assert property (@(posedge clk) disable iff (srst)
      pop |-> (pc_d == stk_top))
    else $error("pop did not take the full stack entry");

  push_saved_a:
    assert property (@(posedge clk) disable iff (srst)
      push |=> (stk_top == $past(pc_q)))
    else $error("pushed counter not on top of stack");

  goto_no_push_a:
    assert property (@(posedge clk) disable iff (srst)
      (op == pcs_pkg::OP_GOTO) |=> $stable(stk_ptr))
    else $error("jump touched the stack");

  low_no_stack_a:
    assert property (@(posedge clk) disable iff (srst)
      (op == pcs_pkg::OP_WLOW) || (op == pcs_pkg::OP_ADD) |=>
        $stable(stk_ptr))
    else $error("low byte write touched the stack");

  seq_no_stack_a:
    assert property (@(posedge clk) disable iff (srst)
      (op == pcs_pkg::OP_SEQ) |=> $stable(stk_ptr))
    else $error("sequential step touched the stack");

  seq_wrap_a:
    assert property (@(posedge clk) disable iff (srst)
      (op == pcs_pkg::OP_SEQ) && (pc_q == 13'h1FFF) |=>
        (pc_q == 13'h0000))
    else $error("counter did not wrap at 13 bits");

  page_reach_a:
    assert property (@(posedge clk) disable iff (srst)
      (op == pcs_pkg::OP_SEQ) && (pc_q == 13'h07FF) |=>
        (pc_q == 13'h0800))
    else $error("counter stopped at the populated page end");

  goto_low_a:
    assert property (@(posedge clk) disable iff (srst)
      (op == pcs_pkg::OP_GOTO) |=>
        (pc_low_byte_q == $past(branch_target[7:0])))
    else $error("jump low byte wrong");

  call_low_a:
    assert property (@(posedge clk) disable iff (srst)
      (op == pcs_pkg::OP_CALL) |=>
        (pc_low_byte_q == $past(branch_target[7:0])))
    else $error("call low byte wrong");

  wlow_low_a:
    assert property (@(posedge clk) disable iff (srst)
      (op == pcs_pkg::OP_WLOW) |=>
        (pc_low_byte_q == $past(low_wr_data)))
    else $error("low byte write not visible");

endmodule

// [pcs_pkg.sv]
// constants and types shared by the program counter and return stack
package pcs_pkg;

  localparam int unsigned PC_W      = 13;
  localparam int unsigned LOW_W     = 8;
  localparam int unsigned HI_W      = 5;
  localparam int unsigned TGT_W     = 11;
  localparam int unsigned STK_DEPTH = 8;
  localparam int unsigned PTR_W     = 3;
  localparam int unsigned PAGE_MSB  = 4;
  localparam int unsigned PAGE_LSB  = 3;

  localparam logic [12:0] PC_RST     = 13'h0000;
  localparam logic [4:0]  LATCH_RST  = 5'h00;
  localparam logic [2:0]  PTR_RST    = 3'h0;
  localparam logic [12:0] INT_VECTOR = 13'h0004;
  localparam logic [12:0] PC_STEP    = 13'h0001;
  localparam logic [2:0]  PTR_STEP   = 3'h1;

  typedef enum logic [2:0] {
    OP_SEQ  = 3'h0,
    OP_INT  = 3'h1,
    OP_RET  = 3'h2,
    OP_CALL = 3'h3,
    OP_GOTO = 3'h4,
    OP_WLOW = 3'h5,
    OP_ADD  = 3'h6,
    OP_HOLD = 3'h7
  } pcs_op_e;

endpackage

// [pcs_latch.sv]
// high-byte latch: five stored bits that feed the upper counter bits
`timescale 1ns/10ps
module pcs_latch (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       wr,
  input  wire logic [7:0] wr_data,
  output logic      [4:0] latch_q
);

  // only the low five bits exist; writes to the top three are dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      latch_q <= pcs_pkg::LATCH_RST;
    end else if (wr) begin
      latch_q <= wr_data[4:0];
    end
  end

endmodule

// [pcs_stack.sv]
// eight-entry circular return-address stack
`timescale 1ns/10ps
module pcs_stack (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        push,
  input  wire logic        pop,
  input  wire logic [12:0] push_data,
  output logic      [12:0] top,
  output logic      [2:0]  ptr_q
);

  logic [12:0] mem_q [pcs_pkg::STK_DEPTH];
  logic [2:0]  top_idx;

  // pointer wraps freely: a ninth push lands on the first entry
  always_ff @(posedge clk) begin
    if (srst) begin
      ptr_q <= pcs_pkg::PTR_RST;
    end else if (push) begin
      ptr_q <= ptr_q + pcs_pkg::PTR_STEP;
    end else if (pop) begin
      ptr_q <= ptr_q - pcs_pkg::PTR_STEP;
    end
  end

  for (genvar i = 0; i < pcs_pkg::STK_DEPTH; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (srst) begin
        mem_q[i] <= pcs_pkg::PC_RST;
      end else if (push && (ptr_q == 3'(i))) begin
        mem_q[i] <= push_data;
      end
    end
  end

  assign top_idx = ptr_q - pcs_pkg::PTR_STEP;
  assign top     = mem_q[top_idx];

endmodule

// [pcs_dec_model.sv]
// decoder model: turns one instruction class into the request lines
`timescale 1ns/10ps
module pcs_dec_model (
  input  wire pcs_pkg::pcs_op_e op,
  output logic                  fetch_adv,
  output logic                  goto_req,
  output logic                  call_req,
  output logic                  ret_req,
  output logic                  int_vec_req,
  output logic                  low_wr,
  output logic                  low_add
);
  // one request per cycle, so the block priority is never relied on
  assign fetch_adv   = (op == pcs_pkg::OP_SEQ);
  assign goto_req    = (op == pcs_pkg::OP_GOTO);
  assign call_req    = (op == pcs_pkg::OP_CALL);
  assign int_vec_req = (op == pcs_pkg::OP_INT);
  assign ret_req     = (op == pcs_pkg::OP_RET);
  assign low_wr      = (op == pcs_pkg::OP_WLOW);
  assign low_add     = (op == pcs_pkg::OP_ADD);
endmodule

// [tb.sv]
// self-checking bench for the program counter and return stack
`timescale 1ns/10ps
module tb;
  typedef struct {
    pcs_pkg::pcs_op_e op;
    logic [10:0]      a;
    logic             w;
    logic [7:0]       d;
    logic [12:0]      pc;
  } pcs_row_s;
  logic             clk;
  logic             srst;
  pcs_pkg::pcs_op_e op;
  logic [10:0]      arg;
  logic             lw;
  logic [7:0]       ld;
  logic [7:0]       lat;
  logic             f_adv, g_req, c_req, r_req, i_req, l_wr, l_add;
  logic [12:0]      pc_q;
  logic [7:0]       pc_low_byte_q;
  logic [7:0]       pc_high_latch_q;
  int               errors;
  int               compares;
  // latch bits 4:3 stay zero except where paging is exercised
  pcs_row_s rows[18] = '{
    '{pcs_pkg::OP_SEQ,  11'h000, 1'b0, 8'h00, 13'h0001},
    '{pcs_pkg::OP_SEQ,  11'h000, 1'b0, 8'h00, 13'h0002},
    '{pcs_pkg::OP_HOLD, 11'h000, 1'b1, 8'hE3, 13'h0002},
    '{pcs_pkg::OP_WLOW, 11'h020, 1'b0, 8'h00, 13'h0320},
    '{pcs_pkg::OP_ADD,  11'h0F0, 1'b0, 8'h00, 13'h0310},
    '{pcs_pkg::OP_CALL, 11'h7FF, 1'b0, 8'h00, 13'h07FF},
    '{pcs_pkg::OP_INT,  11'h000, 1'b0, 8'h00, 13'h0004},
    '{pcs_pkg::OP_RET,  11'h000, 1'b0, 8'h00, 13'h07FF},
    '{pcs_pkg::OP_RET,  11'h000, 1'b0, 8'h00, 13'h0310},
    '{pcs_pkg::OP_HOLD, 11'h000, 1'b1, 8'h18, 13'h0310},
    '{pcs_pkg::OP_GOTO, 11'h123, 1'b0, 8'h00, 13'h1923},
    '{pcs_pkg::OP_SEQ,  11'h000, 1'b0, 8'h00, 13'h1924},
    '{pcs_pkg::OP_WLOW, 11'h0FF, 1'b0, 8'h00, 13'h18FF},
    '{pcs_pkg::OP_HOLD, 11'h000, 1'b1, 8'hFF, 13'h18FF},
    '{pcs_pkg::OP_WLOW, 11'h0FF, 1'b0, 8'h00, 13'h1FFF},
    '{pcs_pkg::OP_SEQ,  11'h000, 1'b0, 8'h00, 13'h0000},
    '{pcs_pkg::OP_WLOW, 11'h0AA, 1'b1, 8'h00, 13'h1FAA},
    '{pcs_pkg::OP_SEQ,  11'h000, 1'b0, 8'h00, 13'h1FAB}
  };

  pcs_dec_model i_dec (.op(op), .fetch_adv(f_adv), .goto_req(g_req), .call_req(c_req), .ret_req(r_req),
    .int_vec_req(i_req), .low_wr(l_wr), .low_add(l_add));
  pcs_top i_dut (.clk(clk), .srst(srst), .fetch_adv(f_adv), .goto_req(g_req), .call_req(c_req),
    .ret_req(r_req), .int_vec_req(i_req), .branch_target(arg), .low_wr(l_wr), .low_wr_data(arg[7:0]),
    .low_add(l_add), .low_add_offset(arg[7:0]), .latch_wr(lw), .latch_wr_data(ld), .pc_q(pc_q),
    .pc_low_byte_q(pc_low_byte_q), .pc_high_latch_q(pc_high_latch_q));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(string nm, logic [12:0] seen, logic [12:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // request held for one edge, then idle so it is not taken twice
  task automatic step(pcs_pkg::pcs_op_e o, logic [10:0] a, logic w, logic [7:0] d);
    @(posedge clk);
    op <= o;
    arg <= a;
    lw <= w;
    ld <= d;
    @(posedge clk);
    op <= pcs_pkg::OP_HOLD;
    lw <= 1'b0;
    #1;
    if (w) lat = {3'h0, d[4:0]};
  endtask

  task automatic look(logic [12:0] exp);
    chk("pc", pc_q, exp);
    chk("low byte", {5'h00, pc_low_byte_q}, {5'h00, exp[7:0]});
    chk("latch", {5'h00, pc_high_latch_q}, {5'h00, lat});
  endtask

  task automatic end_sim();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #(50 * 1000);
    errors++;
    end_sim();
  end

  initial begin
    errors = 0;
    compares = 0;
    lat = 8'h00;
    srst = 1'b1;
    op = pcs_pkg::OP_HOLD;
    arg = 11'h000;
    lw = 1'b0;
    ld = 8'h00;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    #1;
    look(13'h0000);
    $display("test reset done");
    foreach (rows[i]) begin
      step(rows[i].op, rows[i].a, rows[i].w, rows[i].d);
      look(rows[i].pc);
    end
    $display("test rows done");
    // nine calls wrap the eight entries; the first return address is lost
    for (int k = 1; k <= 9; k++) begin
      step(pcs_pkg::OP_CALL, 11'(k), 1'b0, 8'h00);
      look(13'(k));
    end
    for (int j = 1; j <= 9; j++) begin
      step(pcs_pkg::OP_RET, 11'h000, 1'b0, 8'h00);
      look((j <= 8) ? 13'(9 - j) : 13'h0008);
    end
    $display("test circular stack done");
    // back to back: call then return, then interrupt, two steps, return
    @(posedge clk);
    op <= pcs_pkg::OP_CALL;
    arg <= 11'h2AA;
    @(posedge clk);
    op <= pcs_pkg::OP_RET;
    #1;
    chk("pc", pc_q, 13'h02AA);
    @(posedge clk);
    op <= pcs_pkg::OP_INT;
    #1;
    look(13'h0008);
    @(posedge clk);
    op <= pcs_pkg::OP_SEQ;
    #1;
    chk("pc", pc_q, 13'h0004);
    repeat (2) @(posedge clk);
    op <= pcs_pkg::OP_RET;
    @(posedge clk);
    op <= pcs_pkg::OP_HOLD;
    #1;
    look(13'h0008);
    $display("test back-to-back done");
    step(pcs_pkg::OP_HOLD, 11'h000, 1'b1, 8'h1F);
    step(pcs_pkg::OP_WLOW, 11'h055, 1'b0, 8'h00);
    look(13'h1F55);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    lat = 8'h00;
    look(13'h0000);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule
